// [rtu_rotate_unit.sv]
// Function
// - left-through-carry-to-acc: acc[7:1] from operand[6:0], acc[0] from old carry.
// - left-through-carry-to-acc: carry takes operand bit 7; only acc and carry change.
// - plain rotate right: bits shift down, bit 0 to bit 7, written back.
// - rotate right to acc: acc[i] from operand[i+1], acc[7] from operand[0].
// - right through carry: bit 7 gets old carry, carry gets original bit 0.
// - right through carry is a 9-bit ring; result written back to memory.
`timescale 1ns/1ps
`default_nettype none

`include "rtu_defines.svh"

module rtu_rotate_unit
(
  input  wire logic       I_REF_CLK,
  input  wire logic       I_RSTN,
  input  wire logic       I_OP_VALID,
  input  wire logic [1:0] I_OP_CODE,
  input  wire logic [7:0] I_OPERAND,
  input  wire logic       I_ACC_WE,
  input  wire logic [7:0] I_ACC_WDATA,
  input  wire logic       I_FLAGS_WE,
  input  wire logic [5:0] I_FLAGS_WDATA,
  output logic            O_READY,
  output logic            O_DONE,
  output logic [7:0]      O_ACC,
  output logic [5:0]      O_FLAGS,
  output logic            O_MEM_WE,
  output logic [7:0]      O_MEM_WDATA
);

  rtu_rot_if rot_bus ();

  rtu_pkg::rtu_state_t state_r;
  rtu_pkg::rtu_state_t state_nxt;
  rtu_pkg::rtu_op_t    op_r;
  rtu_pkg::rtu_op_t    op_nxt;
  logic [7:0]          operand_r;
  logic [7:0]          operand_nxt;
  logic [7:0]          acc_r;
  logic [7:0]          acc_nxt;
  logic [5:0]          flags_r;
  logic [5:0]          flags_nxt;
  logic                ready_r;
  logic                ready_nxt;
  logic                done_r;
  logic                done_nxt;
  logic                mem_we_r;
  logic                mem_we_nxt;
  logic [7:0]          mem_wdata_r;
  logic [7:0]          mem_wdata_nxt;
  logic                exec_now;

  // ----------------------------------------------------------------
  // rotate datapath
  // ----------------------------------------------------------------
  assign rot_bus.op      = op_r;
  assign rot_bus.operand = operand_r;
  assign rot_bus.cin     = flags_r[`RTU_FLAG_C];

  rtu_rotator u_rotator
  (
    .rot (rot_bus)
  );

  // ----------------------------------------------------------------
  // execute cycle strobe
  // ----------------------------------------------------------------
  assign exec_now = (state_r == rtu_pkg::RTU_ST_EXEC);

  // ----------------------------------------------------------------
  // sequencing
  // ----------------------------------------------------------------
  always_comb
  begin
    state_nxt   = state_r;
    op_nxt      = op_r;
    operand_nxt = operand_r;
    case (state_r)
      rtu_pkg::RTU_ST_IDLE:
      begin
        if (I_OP_VALID)
        begin
          op_nxt      = rtu_pkg::rtu_op_t'(I_OP_CODE);
          operand_nxt = I_OPERAND;
          state_nxt   = rtu_pkg::RTU_ST_EXEC;
        end
      end
      rtu_pkg::RTU_ST_EXEC:
      begin
        state_nxt = rtu_pkg::RTU_ST_RESP;
      end
      rtu_pkg::RTU_ST_RESP:
      begin
        state_nxt = rtu_pkg::RTU_ST_IDLE;
      end
      default:
      begin
        state_nxt = rtu_pkg::RTU_ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge I_REF_CLK)
  begin
    if (!I_RSTN)
    begin
      state_r   <= rtu_pkg::RTU_ST_IDLE;
      op_r      <= rtu_pkg::RTU_OP_ROT_LEFT_CFLAG_ACC;
      operand_r <= `RTU_DATA_RST;
    end
    else
    begin
      state_r   <= state_nxt;
      op_r      <= op_nxt;
      operand_r <= operand_nxt;
    end
  end

  // ----------------------------------------------------------------
  // accumulator
  // ----------------------------------------------------------------
  always_comb
  begin
    acc_nxt = acc_r;
    if (I_ACC_WE)
    begin
      acc_nxt = I_ACC_WDATA;
    end
    if (exec_now && rtu_pkg::rtu_to_acc(op_r))
    begin
      acc_nxt = rot_bus.result;
    end
  end

  always_ff @(posedge I_REF_CLK)
  begin
    if (!I_RSTN)
    begin
      acc_r <= `RTU_ACC_RST;
    end
    else
    begin
      acc_r <= acc_nxt;
    end
  end

  // ----------------------------------------------------------------
  // status flags
  // ----------------------------------------------------------------
  always_comb
  begin
    flags_nxt = flags_r;
    if (I_FLAGS_WE)
    begin
      flags_nxt = I_FLAGS_WDATA;
    end
    if (exec_now && rtu_pkg::rtu_thru_carry(op_r))
    begin
      flags_nxt[`RTU_FLAG_C] = rot_bus.cout;
    end
  end

  always_ff @(posedge I_REF_CLK)
  begin
    if (!I_RSTN)
    begin
      flags_r <= `RTU_FLAGS_RST;
    end
    else
    begin
      flags_r <= flags_nxt;
    end
  end

  // ----------------------------------------------------------------
  // write-back and handshake
  // ----------------------------------------------------------------
  always_comb
  begin
    mem_wdata_nxt = mem_wdata_r;
    mem_we_nxt    = 1'b0;
    done_nxt      = exec_now;
    ready_nxt     = (state_nxt == rtu_pkg::RTU_ST_IDLE);
    if (exec_now && !rtu_pkg::rtu_to_acc(op_r))
    begin
      mem_we_nxt    = 1'b1;
      mem_wdata_nxt = rot_bus.result;
    end
  end

  always_ff @(posedge I_REF_CLK)
  begin
    if (!I_RSTN)
    begin
      mem_we_r    <= 1'b0;
      mem_wdata_r <= `RTU_DATA_RST;
      done_r      <= 1'b0;
      ready_r     <= 1'b0;
    end
    else
    begin
      mem_we_r    <= mem_we_nxt;
      mem_wdata_r <= mem_wdata_nxt;
      done_r      <= done_nxt;
      ready_r     <= ready_nxt;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign O_READY     = ready_r;
  assign O_DONE      = done_r;
  assign O_ACC       = acc_r;
  assign O_FLAGS     = flags_r;
  assign O_MEM_WE    = mem_we_r;
  assign O_MEM_WDATA = mem_wdata_r;

endmodule

`default_nettype wire

// [rtu_defines.svh]
`ifndef RTU_DEFINES_SVH
`define RTU_DEFINES_SVH

// ----------------------------------------------------------------
// operation codes
// ----------------------------------------------------------------
`define RTU_OPC_ROT_LEFT_CFLAG_ACC  2'h0
`define RTU_OPC_ROT_RIGHT_MEM       2'h1
`define RTU_OPC_ROT_RIGHT_ACC       2'h2
`define RTU_OPC_ROT_RIGHT_CFLAG_MEM 2'h3

// ----------------------------------------------------------------
// status flag positions
// ----------------------------------------------------------------
`define RTU_FLAG_C  0
`define RTU_FLAG_AC 1
`define RTU_FLAG_Z  2
`define RTU_FLAG_OV 3
`define RTU_FLAG_PD 4
`define RTU_FLAG_TO 5

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define RTU_ACC_RST   8'h00
`define RTU_FLAGS_RST 6'h00
`define RTU_DATA_RST  8'h00

`endif

// [rtu_pkg.sv]
`include "rtu_defines.svh"

package rtu_pkg;

  typedef enum logic [1:0]
  {
    RTU_OP_ROT_LEFT_CFLAG_ACC  = `RTU_OPC_ROT_LEFT_CFLAG_ACC,
    RTU_OP_ROT_RIGHT_MEM       = `RTU_OPC_ROT_RIGHT_MEM,
    RTU_OP_ROT_RIGHT_ACC       = `RTU_OPC_ROT_RIGHT_ACC,
    RTU_OP_ROT_RIGHT_CFLAG_MEM = `RTU_OPC_ROT_RIGHT_CFLAG_MEM
  } rtu_op_t;

  typedef enum logic [2:0]
  {
    RTU_ST_IDLE = 3'b001,
    RTU_ST_EXEC = 3'b010,
    RTU_ST_RESP = 3'b100
  } rtu_state_t;

  // result goes to accumulator
  function automatic logic rtu_to_acc(input rtu_op_t op);
    rtu_to_acc = (op == RTU_OP_ROT_LEFT_CFLAG_ACC) || (op == RTU_OP_ROT_RIGHT_ACC);
  endfunction

  // op rotates through carry
  function automatic logic rtu_thru_carry(input rtu_op_t op);
    rtu_thru_carry = (op == RTU_OP_ROT_LEFT_CFLAG_ACC) || (op == RTU_OP_ROT_RIGHT_CFLAG_MEM);
  endfunction

endpackage

// [rtu_rot_if.sv]
`timescale 1ns/1ps
`default_nettype none

interface rtu_rot_if;
  rtu_pkg::rtu_op_t op;
  logic [7:0]       operand;
  logic             cin;
  logic [7:0]       result;
  logic             cout;

  modport calc
  (
    input  op,
    input  operand,
    input  cin,
    output result,
    output cout
  );

  modport user
  (
    output op,
    output operand,
    output cin,
    input  result,
    input  cout
  );
endinterface

`default_nettype wire

// [rtu_rotator.sv]
`timescale 1ns/1ps
`default_nettype none

module rtu_rotator
(
  rtu_rot_if.calc rot
);

  logic [7:0] shl;
  logic [7:0] shr;

  // ----------------------------------------------------------------
  // one-place shifts
  // ----------------------------------------------------------------
  genvar i;
  generate
    for (i = 0; i < 7; i++)
    begin : g_shift
      assign shl[i+1] = rot.operand[i];
      assign shr[i]   = rot.operand[i+1];
    end
  endgenerate

  assign shl[0] = rot.cin;
  assign shr[7] = rot.operand[0];

  // ----------------------------------------------------------------
  // result select
  // ----------------------------------------------------------------
  always_comb
  begin
    rot.result = rot.operand;
    rot.cout   = rot.cin;
    case (rot.op)
      rtu_pkg::RTU_OP_ROT_LEFT_CFLAG_ACC:
      begin
        rot.result = shl;
        rot.cout   = rot.operand[7];
      end
      rtu_pkg::RTU_OP_ROT_RIGHT_MEM:
      begin
        rot.result = shr;
      end
      rtu_pkg::RTU_OP_ROT_RIGHT_ACC:
      begin
        rot.result = shr;
      end
      rtu_pkg::RTU_OP_ROT_RIGHT_CFLAG_MEM:
      begin
        rot.result = {rot.cin, shr[6:0]};
        rot.cout   = rot.operand[0];
      end
      default:
      begin
        rot.result = rot.operand;
        rot.cout   = rot.cin;
      end
    endcase
  end

endmodule

`default_nettype wire

// [rtu_rotate_unit_assertions.sv]
`timescale 1ns/1ps
`default_nettype none

module rtu_rotate_unit_assertions
(
  input wire logic       I_REF_CLK,
  input wire logic       I_RSTN,
  input wire logic       I_OP_VALID,
  input wire logic [1:0] I_OP_CODE,
  input wire logic [7:0] I_OPERAND,
  input wire logic       I_FLAGS_WE,
  input wire logic       O_READY,
  input wire logic       O_DONE,
  input wire logic [7:0] O_ACC,
  input wire logic [5:0] O_FLAGS,
  input wire logic       O_MEM_WE,
  input wire logic [7:0] O_MEM_WDATA
);
  // ----------------------------------------------------------------
  // operand and carry seen by the op
  // ----------------------------------------------------------------
  logic [7:0] d_r;
  logic       c_r;

  always_ff @(posedge I_REF_CLK)
  begin
    c_r <= O_FLAGS[0];
    if (I_OP_VALID && O_READY)
      d_r <= I_OPERAND;
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking @(posedge I_REF_CLK); endclocking
  default disable iff (!I_RSTN);

  sequence s_take(logic [1:0] op);
    I_OP_VALID && O_READY && I_OP_CODE == op;
  endsequence

  a_left_acc:
    assert property (s_take(2'h0) |-> ##2 O_DONE && !O_MEM_WE && O_ACC == {d_r[6:0], c_r})
      else $error("left rotate into acc wrong");
  a_left_carry:
    assert property (s_take(2'h0) ##1 !I_FLAGS_WE |=> O_FLAGS == {$past(O_FLAGS[5:1]), d_r[7]})
      else $error("carry after left rotate wrong");
  a_right_mem:
    assert property (s_take(2'h1) |-> ##2 O_MEM_WE && O_MEM_WDATA == {d_r[0], d_r[7:1]})
      else $error("right rotate write-back wrong");
  a_right_acc:
    assert property (s_take(2'h2) |-> ##2 O_DONE && !O_MEM_WE && O_ACC == {d_r[0], d_r[7:1]})
      else $error("right rotate into acc wrong");
  a_ring_carry:
    assert property (s_take(2'h3) ##1 !I_FLAGS_WE |=> O_FLAGS == {$past(O_FLAGS[5:1]), d_r[0]})
      else $error("carry after right ring wrong");
  a_ring_data:
    assert property (s_take(2'h3) |-> ##2 O_MEM_WE && O_MEM_WDATA == {c_r, d_r[7:1]})
      else $error("right ring write-back wrong");
  a_flags_kept:
    assert property ((s_take(2'h1) or s_take(2'h2)) ##1 !I_FLAGS_WE |=> $stable(O_FLAGS))
      else $error("flags changed by plain rotate");
  a_done_pulse:
    assert property (O_DONE |=> !O_DONE && !O_MEM_WE)
      else $error("done or write longer than one cycle");
endmodule

bind rtu_rotate_unit rtu_rotate_unit_assertions i_chk
(
  .I_REF_CLK(I_REF_CLK), .I_RSTN(I_RSTN), .I_OP_VALID(I_OP_VALID), .I_OP_CODE(I_OP_CODE),
  .I_OPERAND(I_OPERAND), .I_FLAGS_WE(I_FLAGS_WE), .O_READY(O_READY), .O_DONE(O_DONE),
  .O_ACC(O_ACC), .O_FLAGS(O_FLAGS), .O_MEM_WE(O_MEM_WE), .O_MEM_WDATA(O_MEM_WDATA)
);

`default_nettype wire

// [test_rtu_rotate_unit.sv]
`timescale 1ns/1ps
`default_nettype none

module test_rtu_rotate_unit;
  logic       clk    = 1'b0;
  logic       rstn   = 1'b0;
  logic       vld    = 1'b0;
  logic [1:0] opc    = 2'h0;
  logic [7:0] opnd   = 8'h00;
  logic       acc_we = 1'b0;
  logic [7:0] acc_wd = 8'h00;
  logic       flg_we = 1'b0;
  logic [5:0] flg_wd = 6'h00;
  logic       rdy;
  logic       done;
  logic       mem_we;
  logic [7:0] acc;
  logic [7:0] mem_wd;
  logic [5:0] flg;
  int         mismatches = 0;
  int         n_tests    = 0;

  rtu_rotate_unit i_rtu_rotate_unit
  (
    .I_REF_CLK(clk), .I_RSTN(rstn), .I_OP_VALID(vld), .I_OP_CODE(opc), .I_OPERAND(opnd),
    .I_ACC_WE(acc_we), .I_ACC_WDATA(acc_wd), .I_FLAGS_WE(flg_we), .I_FLAGS_WDATA(flg_wd),
    .O_READY(rdy), .O_DONE(done), .O_ACC(acc), .O_FLAGS(flg), .O_MEM_WE(mem_we),
    .O_MEM_WDATA(mem_wd)
  );

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  initial forever #2.5 clk = ~clk;

  task automatic close_out();
    if (mismatches == 0 && n_tests > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic load(input logic [7:0] a, input logic [5:0] f);
    @(posedge clk);
    acc_we <= 1'b1;
    acc_wd <= a;
    flg_we <= 1'b1;
    flg_wd <= f;
    @(posedge clk);
    acc_we <= 1'b0;
    flg_we <= 1'b0;
  endtask

  // one op, then judge the done cycle
  task automatic op_chk(input logic [1:0] op, input logic [7:0] d, input logic [7:0] a,
                        input logic [5:0] f, input logic we, input logic [7:0] m);
    int n;
    @(posedge clk);
    vld  <= 1'b1;
    opc  <= op;
    opnd <= d;
    n = 0;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (rdy !== 1'b1 && n < 20);
    if (rdy !== 1'b1)
      mismatches++;
    vld <= 1'b0;
    @(posedge clk);
    #1;
    check({7'h00, done}, 8'h01);
    check(acc, a);
    check({2'h0, flg}, {2'h0, f});
    check({7'h00, mem_we}, {7'h00, we});
    check(mem_wd, m);
  endtask

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_reset();
    @(posedge clk);
    #1;
    check({7'h00, rdy}, 8'h01);
    check(acc, 8'h00);
    check({2'h0, flg}, 8'h00);
  endtask

  task automatic t_left();
    load(8'h55, 6'h3e);
    op_chk(2'h0, 8'h80, 8'h00, 6'h3f, 1'b0, 8'h00);
    op_chk(2'h0, 8'h01, 8'h03, 6'h3e, 1'b0, 8'h00);
  endtask

  task automatic t_right();
    load(8'h5a, 6'h15);
    op_chk(2'h1, 8'h01, 8'h5a, 6'h15, 1'b1, 8'h80);
    op_chk(2'h1, 8'h6c, 8'h5a, 6'h15, 1'b1, 8'h36);
    op_chk(2'h2, 8'h03, 8'h81, 6'h15, 1'b0, 8'h36);
  endtask

  task automatic t_ring();
    load(8'hc3, 6'h01);
    op_chk(2'h3, 8'h02, 8'hc3, 6'h00, 1'b1, 8'h81);
    op_chk(2'h3, 8'h01, 8'hc3, 6'h01, 1'b1, 8'h00);
  endtask

  // request held through the busy cycles must not be taken again
  task automatic t_busy();
    @(posedge clk);
    vld  <= 1'b1;
    opc  <= 2'h1;
    opnd <= 8'h02;
    @(posedge clk);
    opc  <= 2'h2;
    opnd <= 8'hff;
    @(posedge clk);
    #1;
    check({7'h00, mem_we}, 8'h01);
    check(mem_wd, 8'h01);
    @(posedge clk);
    vld <= 1'b0;
    repeat (2) @(posedge clk);
    #1;
    check({7'h00, done}, 8'h00);
    check({7'h00, rdy}, 8'h01);
    check(acc, 8'hc3);
    check({2'h0, flg}, 8'h01);
  endtask

  initial
  begin
    repeat (3) @(posedge clk);
    rstn <= 1'b1;
    t_reset();
    t_left();
    t_right();
    t_ring();
    t_busy();
    close_out();
  end

  initial
  begin
    repeat (2000) @(posedge clk);
    mismatches++;
    close_out();
  end
endmodule

`default_nettype wire
